/* rtl/divider_regs.vh */
// Purpose: register map and constants of the integer divider
// Assumes: 32-bit APB, byte addresses
// Notes:   definitions only
`ifndef DIVIDER_REGS_VH
`define DIVIDER_REGS_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define ADDR_W          12
`define OFS_UNUMERATOR  12'h060
`define OFS_UDENOM      12'h064
`define OFS_SNUMERATOR  12'h068
`define OFS_SDENOM      12'h06c
`define OFS_QUOTIENT    12'h070
`define OFS_REMAINDER   12'h074
`define OFS_CTRL_STATUS 12'h078
`define OFS_IRQ_STATUS  12'h0f0
`define OFS_IRQ_MASK    12'h0f4

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BIT_DONE        0
`define BIT_DIRTY       1
`define BIT_ABORT       1
`define IRQ_W           2
`define RST_WORD        32'h0000_0000
`define RST_DONE        1'b1
`define RST_DIRTY       1'b0
`define RST_IRQ         2'h0
`define ZERO_HIGH       30'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define DIV_STEPS       6'h20
`define STEP_ONE        6'h01
`define STEP_ZERO       6'h00

`endif

/* rtl/divider_unit.v */
// Purpose: memory-mapped 32-bit signed/unsigned integer divider with APB slave
// Assumes: single clock sys_clk at 10 MHz, synchronous active-low reset nrst
// Notes:   one quotient bit per clock, 32 cycles per division
//          irq_status at 0x0f0 is write-one-to-clear, irq_mask at 0x0f4
//          bit 0 of both flags a completed division, bit 1 an abandoned one
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "divider_regs.vh"

module divider_unit (
	// clock and reset
	input  wire                sys_clk,
	input  wire                nrst,
	// apb slave
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [`ADDR_W-1:0]  paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr,
	// interrupt
	output reg                 irq
);

	reg  [31:0]          any_numerator_alias;
	reg  [31:0]          any_denominator_alias;
	reg  [31:0]          quotient;
	reg  [31:0]          remainder;
	reg                  calc_done_flag;
	reg                  modified_since_read_flag;
	reg  [31:0]          work_quo;
	reg  [31:0]          work_rem;
	reg  [31:0]          work_den;
	reg                  neg_quo;
	reg                  neg_rem;
	reg  [5:0]           steps_left;
	reg  [`IRQ_W-1:0]    irq_status;
	reg  [`IRQ_W-1:0]    irq_mask;
	reg  [31:0]          rd_mux;
	reg                  rd_hit;
	reg                  start;
	reg                  start_signed;
	reg  [31:0]          next_num;
	reg  [31:0]          next_den;
	reg  [31:0]          mag_num;
	reg  [31:0]          mag_den;
	wire [`IRQ_W-1:0]    irq_event;
	wire [`IRQ_W-1:0]    irq_clear;
	wire [`IRQ_W-1:0]    next_irq_status;
	genvar               g;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire                 setup     = psel & ~penable;
	wire                 access    = psel & penable & pready;
	wire                 wr        = access & pwrite;
	wire                 rd        = access & ~pwrite;
	wire                 wr_unum   = wr & (paddr == `OFS_UNUMERATOR);
	wire                 wr_uden   = wr & (paddr == `OFS_UDENOM);
	wire                 wr_snum   = wr & (paddr == `OFS_SNUMERATOR);
	wire                 wr_sden   = wr & (paddr == `OFS_SDENOM);
	wire                 wr_quo    = wr & (paddr == `OFS_QUOTIENT);
	wire                 wr_rem    = wr & (paddr == `OFS_REMAINDER);
	wire                 wr_result = wr_quo | wr_rem;
	wire                 rd_quo    = rd & (paddr == `OFS_QUOTIENT);
	wire                 wr_mask   = wr & (paddr == `OFS_IRQ_MASK);
	wire                 wr_status = wr & (paddr == `OFS_IRQ_STATUS);

	// ----------------------------------------
	// one restoring step per clock
	// ----------------------------------------
	wire                 last_step = ~calc_done_flag & (steps_left == `STEP_ONE);
	wire [32:0]          trial     = {work_rem[31:0], work_quo[31]} - {1'b0, work_den};
	wire                 fits      = ~trial[32];
	wire [31:0]          step_quo  = {work_quo[30:0], fits};
	wire [31:0]          step_rem  = fits ? trial[31:0] : {work_rem[30:0], work_quo[31]};
	wire                 abort     = ~calc_done_flag & (start | wr_result);

	// ----------------------------------------
	// operand capture
	// ----------------------------------------
	always @* begin
		start        = wr_unum | wr_uden | wr_snum | wr_sden;
		start_signed = wr_snum | wr_sden;
		next_num     = (wr_unum | wr_snum) ? pwdata : any_numerator_alias;
		next_den     = (wr_uden | wr_sden) ? pwdata : any_denominator_alias;
		// magnitudes feed the unsigned core
		mag_num      = (start_signed & next_num[31]) ? (~next_num + 32'h1) : next_num;
		mag_den      = (start_signed & next_den[31]) ? (~next_den + 32'h1) : next_den;
	end

	// ----------------------------------------
	// operand registers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			any_numerator_alias   <= `RST_WORD;
			any_denominator_alias <= `RST_WORD;
		end else if (start) begin
			any_numerator_alias   <= next_num;
			any_denominator_alias <= next_den;
		end
	end

	// ----------------------------------------
	// result signs
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			neg_quo <= 1'b0;
			neg_rem <= 1'b0;
		end else if (start) begin
			neg_quo <= start_signed & (next_num[31] ^ next_den[31]);
			neg_rem <= start_signed & next_num[31];
		end
	end

	// ----------------------------------------
	// step counter and done flag
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			calc_done_flag <= `RST_DONE;
			steps_left     <= `STEP_ZERO;
		end else if (start) begin
			calc_done_flag <= 1'b0;
			steps_left     <= `DIV_STEPS;
		end else if (wr_result) begin
			calc_done_flag <= 1'b1;
			steps_left     <= `STEP_ZERO;
		end else if (!calc_done_flag) begin
			steps_left <= steps_left - `STEP_ONE;
			if (last_step) begin
				calc_done_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// shift and subtract registers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			work_quo <= `RST_WORD;
			work_rem <= `RST_WORD;
			work_den <= `RST_WORD;
		end else if (start) begin
			work_quo <= mag_num;
			work_den <= mag_den;
			work_rem <= `RST_WORD;
		end else if (!calc_done_flag & !wr_result) begin
			work_quo <= step_quo;
			work_rem <= step_rem;
		end
	end

	// ----------------------------------------
	// result registers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			quotient  <= `RST_WORD;
			remainder <= `RST_WORD;
		end else if (wr_result) begin
			if (wr_quo) begin
				quotient <= pwdata;
			end
			if (wr_rem) begin
				remainder <= pwdata;
			end
		end else if (last_step & ~start) begin
			quotient  <= neg_quo ? (~step_quo + 32'h1) : step_quo;
			remainder <= neg_rem ? (~step_rem + 32'h1) : step_rem;
		end
	end

	// ----------------------------------------
	// dirty flag
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!nrst) begin
			modified_since_read_flag <= `RST_DIRTY;
		end else if (start | wr_result) begin
			modified_since_read_flag <= 1'b1;
		// only a quotient read clears dirty
		end else if (rd_quo) begin
			modified_since_read_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// bit 0 completed, bit 1 aborted
	assign irq_event[`BIT_DONE]  = last_step & ~start & ~wr_result;
	assign irq_event[`BIT_ABORT] = abort;
	assign irq_clear             = wr_status ? pwdata[`IRQ_W-1:0] : `RST_IRQ;

	// set wins over a same-cycle clear
	generate
		for (g = 0; g < `IRQ_W; g = g + 1) begin : irq_bit
			assign next_irq_status[g] = irq_event[g] | (irq_status[g] & ~irq_clear[g]);
		end
	endgenerate

	always @(posedge sys_clk) begin
		if (!nrst) begin
			irq_status <= `RST_IRQ;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always @(posedge sys_clk) begin
		if (!nrst) begin
			irq_mask <= `RST_IRQ;
		end else if (wr_mask) begin
			irq_mask <= pwdata[`IRQ_W-1:0];
		end
	end

	// level output, one cycle behind the status
	always @(posedge sys_clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------
	// apb read path
	// ----------------------------------------
	always @* begin
		rd_mux = `RST_WORD;
		rd_hit = 1'b1;
		case (paddr)
			`OFS_UNUMERATOR,
			`OFS_SNUMERATOR:  rd_mux = any_numerator_alias;
			`OFS_UDENOM,
			`OFS_SDENOM:      rd_mux = any_denominator_alias;
			`OFS_QUOTIENT:    rd_mux = quotient;
			`OFS_REMAINDER:   rd_mux = remainder;
			`OFS_CTRL_STATUS: rd_mux = {`ZERO_HIGH, modified_since_read_flag, calc_done_flag};
			`OFS_IRQ_STATUS:  rd_mux = {`ZERO_HIGH, irq_status};
			`OFS_IRQ_MASK:    rd_mux = {`ZERO_HIGH, irq_mask};
			default:          rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	// answers in the first access cycle, no wait states
	always @(posedge sys_clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~rd_hit;
		end
	end

	// read data taken at the setup edge, held until the next read
	always @(posedge sys_clk) begin
		if (!nrst) begin
			prdata <= `RST_WORD;
		end else if (setup & ~pwrite) begin
			prdata <= rd_mux;
		end
	end

endmodule // divider_unit

/* verif/divider_props.sv */
// Purpose: port checks of divider_unit
// Assumes: zero-wait apb, status word at 12'h078
// Notes:   since counts edges after an operand write
`timescale 1ns/100ps
module divider_props (
	input wire        sys_clk,
	input wire        nrst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready
);
	wire       acc = psel & penable & pready;
	wire       csr = acc & !pwrite & (paddr == 12'h078);
	wire       rdq = acc & !pwrite & (paddr == 12'h070);
	wire       wrx = acc & pwrite & (paddr >= 12'h060) & (paddr < 12'h078);
	wire       res = wrx & (paddr > 12'h06c);
	wire       opw = wrx & (paddr < 12'h070);
	reg  [6:0] since;
	always @(posedge sys_clk)
		since <= (!nrst || res) ? 7'h7f : opw ? 7'h00 : since + {6'h00, since != 7'h7f};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	answer_next_a: assert property (psel && !penable |=> pready) else $error("no answer");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	csr_reserved_a: assert property (csr |-> prdata[31:2] == 30'h0)
		else $error("reserved bits set");
	busy_flag_a: assert property (csr && since < 7'h20 |-> !prdata[0])
		else $error("ready while busy");
	done_flag_a: assert property (csr && since > 7'h20 |-> prdata[0])
		else $error("not ready after count");
	abort_ready_a: assert property ((res ##2 csr) |-> prdata[0])
		else $error("ready not set");
	dirty_set_a: assert property ((wrx ##2 csr) |-> prdata[1])
		else $error("dirty not set");
	dirty_clear_a: assert property ((rdq ##2 csr) |-> !prdata[1])
		else $error("dirty not cleared");
endmodule // divider_props
bind divider_unit divider_props chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready));

/* verif/tb.sv */
// Purpose: self-checking bench of divider_unit
// Assumes: zero-wait apb slave, 100 ns clock
// Notes:   psel stays up between back-to-back transfers
`timescale 1ns/100ps
module tb;
	reg         sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire        pready, pslverr, irq;
	integer     failures = 0, num_checks = 0;
	divider_unit dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	always #50 sys_clk = ~sys_clk;
	task chk(input string n, input [31:0] e, input [31:0] g);
		num_checks = num_checks + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		penable <= 1'b0;
	endtask
	task rchk(input string n, input [11:0] a, input [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task idle(input integer c);
		psel <= 1'b0;
		repeat (c) @(posedge sys_clk);
	endtask
	task register_map;
		rchk("csr", 12'h078, 32'h1);
		rchk("quotient", 12'h070, 32'h0);
		rchk("numerator", 12'h060, 32'h0);
		xfer(1'b1, 12'h078, 32'h0);
		rchk("csr kept", 12'h078, 32'h1);
		rchk("unmapped", 12'h100, 32'h0);
		chk("pslverr", 32'h1, err);
	endtask
	task divide(input s, input [31:0] n, input [31:0] d, input [31:0] q, input [31:0] r);
		xfer(1'b1, s ? 12'h068 : 12'h060, n);
		xfer(1'b1, s ? 12'h06c : 12'h064, d);
		rd = 32'h0;
		repeat (40) if (rd[0] !== 1'b1) xfer(1'b0, 12'h078, 32'h0);
		chk("ready", 32'h1, rd[0]);
		rchk("remainder", 12'h074, r);
		rchk("dirty kept", 12'h078, 32'h3);
		rchk("quotient", 12'h070, q);
		rchk("dirty cleared", 12'h078, 32'h1);
		rchk("operand", s ? 12'h064 : 12'h06c, d);
	endtask
	task restart_abort;
		xfer(1'b1, 12'h060, 32'h32);
		xfer(1'b1, 12'h064, 32'h5);
		xfer(1'b1, 12'h064, 32'ha);
		rchk("busy", 12'h078, 32'h2);
		idle(40);
		rchk("restart result", 12'h070, 32'h5);
		xfer(1'b1, 12'h060, 32'h3e8);
		xfer(1'b1, 12'h074, 32'h1234);
		rchk("abort", 12'h078, 32'h3);
		rchk("restored", 12'h074, 32'h1234);
		xfer(1'b1, 12'h064, 32'h7);
		xfer(1'b1, 12'h070, 32'h55);
		rchk("quotient restored", 12'h070, 32'h55);
		rchk("remainder kept", 12'h074, 32'h1234);
		rchk("clean after quotient", 12'h078, 32'h1);
	endtask
	task irq_flow;
		chk("irq masked", 32'h0, irq);
		rchk("irq status", 12'h0f0, 32'h3);
		xfer(1'b1, 12'h0f4, 32'h1);
		idle(3);
		chk("irq raised", 32'h1, irq);
		xfer(1'b1, 12'h0f0, 32'h1);
		idle(3);
		chk("irq cleared", 32'h0, irq);
		rchk("irq status left", 12'h0f0, 32'h2);
	endtask
	task results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		register_map;
		divide(1'b0, 32'h64, 32'h7, 32'he, 32'h2);
		divide(1'b1, 32'h7, 32'hfffffffe, 32'hfffffffd, 32'h1);
		divide(1'b1, 32'hfffffff9, 32'hfffffffe, 32'h3, 32'hffffffff);
		restart_abort;
		irq_flow;
		results;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		failures = failures + 1;
		results;
	end
endmodule // tb
